//--- shared/sarseq_pkg.sv
// shared constants and types for the sar adc sequencer
package sarseq_pkg;
  // register offsets, start bit and reset values
  localparam logic [7:0] ADDR_CONV_DATA = 8'h04;
  localparam logic [7:0] ADDR_CONV_START = 8'h20;
  localparam logic [3:0] CONV_START_RESET = 4'h0;
  localparam int START_BIT = 0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // instruction cycle = 8 system clocks of 10 ns
  localparam int INSTR_NS = 80;
  localparam int CLK_NS = 10;
  localparam int INSTR_CLKS = INSTR_NS / CLK_NS;
  localparam logic [3:0] INSTR_LAST = 4'(INSTR_CLKS - 1);
  // schedule in instruction cycles
  localparam logic [4:0] FIRST_BIT_INSTR = 5'h04;
  localparam logic [4:0] INSTR_PER_BIT = 5'h03;
  localparam logic [4:0] CONV_INSTR = 5'h19;
  localparam logic [1:0] CMP_INSTR = 2'h3;
  // sampling window in system clocks
  localparam int SAMPLE_CLKS = 14;
  localparam int SAMPLE_PERIOD_CLKS = 48;
  localparam logic [5:0] SAMPLE_LAST = 6'(SAMPLE_PERIOD_CLKS - 1);
  localparam logic [5:0] SAMPLE_END = 6'(SAMPLE_CLKS);
  localparam logic [2:0] MSB_IDX = 3'h7;

  typedef enum logic [2:0] {
    SARSQ_IDLE = 3'b001,
    SARSQ_CONV = 3'b010,
    SARSQ_CMP = 3'b100
  } sarsq_state_e;

  // one peripheral transfer from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] buf_data;
  } sarsq_xfer_s;
endpackage

//--- core/sarsq_sequencer.sv
// sar adc control and sequencing logic
`timescale 1ns/10ps
// Summary of operation
// - writing 1 to start flag begins conversion in successive mode; flag self-clears once started
// - setting the start flag clears the data register in both modes
// - in single mode a data register write starts a compare
// - data write at 04H takes low two buffer nibbles only
// - data read fills low two buffer nibbles, upper byte retained
// - mode bit 0 selects successive, 1 selects single compare
// - successive mode resolves 8 bits msb first, storing each bit
// - full successive conversion takes 25 instruction cycles
// - three instruction cycles per bit after the msb, bits stored as decided
// - done flag sets when lsb is stored
// - msb valid after 4 instructions, then every 3, all after 25
// - five samples per conversion, 14 clocks long (last one cut short), every 48 clocks
// - done flag zero at start and during conversion; start write clears it
// - compare flag 0 when input below dac, 1 when above
// - data write clears compare flag; result valid third instruction later
// - data writes ignored while mode bit is 0
module sarsq_sequencer
  import sarseq_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire sarsq_xfer_s xfer_in,
  input wire logic conv_mode_select_in,
  input wire logic comparator_in,
  output logic [15:0] transfer_buffer_out,
  output logic [3:0] start_reg_out,
  output logic [7:0] dac_code_out,
  output logic sample_out,
  output logic conv_done_flag_out,
  output logic compare_result_flag_out,
  output logic busy_out
);

  sarsq_state_e state;
  logic [7:0] conv_data_reg;
  logic conv_start_flag;
  logic [3:0] instr_div;
  logic instr_en;
  logic [4:0] instr_cnt;
  logic [1:0] bit_phase;
  logic [2:0] bit_idx;
  logic [1:0] cmp_cnt;
  logic [5:0] samp_cnt;
  logic cmp_sync1;
  logic cmp_sync2;
  logic start_wr;
  logic start_set;
  logic data_wr;
  logic data_rd;
  logic decide;
  logic [7:0] bit_sel;
  logic [7:0] next_conv_data;
  genvar gi;

  assign start_wr = xfer_in.wr && (xfer_in.addr == ADDR_CONV_START);
  assign start_set = start_wr && xfer_in.buf_data[START_BIT];
  assign data_wr = xfer_in.wr && (xfer_in.addr == ADDR_CONV_DATA) && conv_mode_select_in;
  assign data_rd = xfer_in.rd && (xfer_in.addr == ADDR_CONV_DATA);
  assign decide = instr_en && (state == SARSQ_CONV) && (bit_phase == 2'd0);

  ////////////////////////////////////////////////////////////////////////////
  // comparator comes from the analog side, so synchronise it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cmp_sync1 <= 1'b0;
      cmp_sync2 <= 1'b0;
    end else begin
      cmp_sync1 <= comparator_in;
      cmp_sync2 <= cmp_sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction-cycle enable; restarts on a start so phase is exact
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || start_set || data_wr) begin
      instr_div <= 4'h0;
      instr_en <= 1'b0;
    end else begin
      instr_en <= (instr_div == INSTR_LAST);
      instr_div <= (instr_div == INSTR_LAST) ? 4'h0 : instr_div + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start flag: reads 1 only until the sequence has begun
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      conv_start_flag <= 1'b0;
    end else if (start_set) begin
      conv_start_flag <= 1'b1;
    end else begin
      conv_start_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= SARSQ_IDLE;
    end else if (start_set) begin
      // restart from msb even mid-conversion
      state <= conv_mode_select_in ? SARSQ_IDLE : SARSQ_CONV;
    end else if (data_wr) begin
      state <= SARSQ_CMP;
    end else if (instr_en) begin
      case (state)
        SARSQ_IDLE: begin
          state <= SARSQ_IDLE;
        end
        SARSQ_CONV: begin
          if (bit_phase == 2'd0 && bit_idx == 3'h0) begin
            state <= SARSQ_IDLE;
          end
        end
        SARSQ_CMP: begin
          if (cmp_cnt == CMP_INSTR - 2'd1) begin
            state <= SARSQ_IDLE;
          end
        end
        default: begin
          state <= SARSQ_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instructions spent in the current conversion
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || start_set) begin
      instr_cnt <= 5'h00;
    end else if (instr_en && state == SARSQ_CONV && !data_wr) begin
      instr_cnt <= instr_cnt + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase within a bit; the first bit waits one instruction longer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bit_phase <= 2'd0;
    end else if (start_set) begin
      bit_phase <= 2'(FIRST_BIT_INSTR - 5'h01);
    end else if (instr_en && state == SARSQ_CONV && !data_wr) begin
      if (bit_phase == 2'd0) begin
        // 3 instructions per bit after the first decision
        bit_phase <= 2'(INSTR_PER_BIT - 5'h01);
      end else begin
        bit_phase <= bit_phase - 2'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit under trial, msb first
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || start_set) begin
      bit_idx <= MSB_IDX;
    end else if (decide && !data_wr) begin
      bit_idx <= bit_idx - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare wait in instructions
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || data_wr) begin
      cmp_cnt <= 2'd0;
    end else if (instr_en && state == SARSQ_CMP && !start_set) begin
      cmp_cnt <= cmp_cnt + 2'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-hot select of the bit under trial
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit_sel
      assign bit_sel[gi] = (bit_idx == 3'(gi));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // data register: cleared on start, bits stored as decided
  always_comb begin
    next_conv_data = conv_data_reg;
    if (start_set) begin
      next_conv_data = DATA_RESET;
    end else if (data_wr) begin
      // upper buffer byte is ignored
      next_conv_data = xfer_in.buf_data[7:0];
    end else if (decide) begin
      // partial results readable before done
      next_conv_data = (conv_data_reg & ~bit_sel) | (bit_sel & {8{cmp_sync2}});
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      conv_data_reg <= DATA_RESET;
    end else begin
      conv_data_reg <= next_conv_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dac trial code: decided bits, trial 1 at the current bit
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dac_code_out <= DATA_RESET;
    end else if (state == SARSQ_CONV && !decide) begin
      dac_code_out <= conv_data_reg | bit_sel;
    end else begin
      dac_code_out <= conv_data_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sampling strobe, 14 of every 48 clocks while converting
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || start_set || state != SARSQ_CONV) begin
      samp_cnt <= 6'h00;
      sample_out <= 1'b0;
    end else begin
      samp_cnt <= (samp_cnt == SAMPLE_LAST) ? 6'h00 : samp_cnt + 6'h01;
      sample_out <= (samp_cnt < SAMPLE_END);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // done flag; set wins over a clearing write in the same cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      conv_done_flag_out <= 1'b0;
    end else if (decide && bit_idx == 3'h0) begin
      conv_done_flag_out <= 1'b1;
    end else if (start_wr) begin
      conv_done_flag_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare flag; a new compare data write clears it first
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      compare_result_flag_out <= 1'b0;
    end else if (data_wr) begin
      compare_result_flag_out <= 1'b0;
    end else if (instr_en && state == SARSQ_CMP && cmp_cnt == CMP_INSTR - 2'd1) begin
      compare_result_flag_out <= cmp_sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads of the data register and start flag into the transfer buffer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      transfer_buffer_out <= 16'h0000;
    end else if (data_rd) begin
      transfer_buffer_out[7:0] <= conv_data_reg;
    end else if (xfer_in.rd && xfer_in.addr == ADDR_CONV_START) begin
      transfer_buffer_out[3:0] <= {3'b000, conv_start_flag};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start register mirror
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      start_reg_out <= CONV_START_RESET;
    end else begin
      start_reg_out <= {3'b000, conv_start_flag};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy lags the state by one clock, unlike the done and compare flags
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state != SARSQ_IDLE);
    end
  end

endmodule

//--- testbench/sarsq_analog_model.sv
// comparator stand-in: analog level against the dac code
`timescale 1ns/10ps
module sarsq_analog_model (
  input wire logic [7:0] dac_code_in,
  input wire logic [7:0] level_in,
  output logic comparator_out
);
  // level is half a step above its code, so a tie reads as above
  assign comparator_out = level_in >= dac_code_in;
endmodule

//--- testbench/sarsq_checker.sv
// port assertions for the sequencer
`timescale 1ns/10ps
module sarsq_checker
  import sarseq_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire sarsq_xfer_s xfer_in,
  input wire logic conv_mode_select_in,
  input wire logic [15:0] transfer_buffer_out,
  input wire logic [3:0] start_reg_out,
  input wire logic sample_out,
  input wire logic conv_done_flag_out,
  input wire logic compare_result_flag_out,
  input wire logic busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire ws = xfer_in.wr && xfer_in.addr == ADDR_CONV_START;
  wire wd = xfer_in.wr && xfer_in.addr == ADDR_CONV_DATA;
  wire go = ws && xfer_in.buf_data[START_BIT];
  logic [8:0] n;
  // saturates so an old start never wraps back into the window
  always_ff @(posedge clk_in) n <= (sys_rst_in || go) ? 9'h000 : n + 9'(n != 9'h1ff);
  property p_clr; ws |=> !conv_done_flag_out; endproperty
  a_clr: assert property (p_clr) else $error("done kept");
  property p_go; go |=> ##1 start_reg_out == 4'h1 ##1 start_reg_out == 4'h0; endproperty
  a_go: assert property (p_go) else $error("start pulse");
  property p_busy; go && !conv_mode_select_in |=> ##1 busy_out; endproperty
  a_busy: assert property (p_busy) else $error("no busy");
  property p_idle; $rose(busy_out) && !conv_mode_select_in |-> !conv_done_flag_out; endproperty
  a_idle: assert property (p_idle) else $error("done in run");
  property p_cmp; wd && conv_mode_select_in |=> !compare_result_flag_out; endproperty
  a_cmp: assert property (p_cmp) else $error("cmp kept");
  property p_smp; $rose(sample_out) |-> ##13 (sample_out || !busy_out) ##1 !sample_out; endproperty
  a_smp: assert property (p_smp) else $error("sample width");
  property p_end; $rose(conv_done_flag_out) && !conv_mode_select_in |-> n >= 9'd195 && n <= 9'd215; endproperty
  a_end: assert property (p_end) else $error("done time");
  property p_keep; xfer_in.rd |=> transfer_buffer_out[15:8] == $past(transfer_buffer_out[15:8]); endproperty
  a_keep: assert property (p_keep) else $error("upper byte");
endmodule
bind sarsq_sequencer sarsq_checker sarsq_checker_inst (.clk_in, .sys_rst_in, .xfer_in, .conv_mode_select_in,
  .transfer_buffer_out, .start_reg_out, .sample_out, .conv_done_flag_out, .compare_result_flag_out, .busy_out);

//--- testbench/test_sar_adc_sequencer.sv
// bench for the sar adc sequencer
`timescale 1ns/10ps
module test_sar_adc_sequencer;
  import sarseq_pkg::*;
  logic clk_in = 0, rst = 1, md = 0, cmp, smp, dn, cf, bz;
  sarsq_xfer_s x = '0;
  logic [15:0] q;
  logic [7:0] dac, lv = 0, d = 0;
  logic [3:0] st;
  int n_mismatch = 0, n_compared = 0, seed = 18293;
  always #5 clk_in = ~clk_in;
  sarsq_sequencer sarsq_sequencer_inst (.clk_in(clk_in), .sys_rst_in(rst), .xfer_in(x), .conv_mode_select_in(md),
    .comparator_in(cmp), .transfer_buffer_out(q), .start_reg_out(st), .dac_code_out(dac), .sample_out(smp),
    .conv_done_flag_out(dn), .compare_result_flag_out(cf), .busy_out(bz));
  sarsq_analog_model sarsq_analog_model_inst (.dac_code_in(dac), .level_in(lv), .comparator_out(cmp));
  task automatic chk(string s, logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic w(int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic xf(logic wr, logic [7:0] a, logic [15:0] v);
    @(posedge clk_in);
    x <= '{wr, !wr, a, v};
    @(posedge clk_in);
    x <= '0;
    w(1);
  endtask
  task automatic rc(string s, logic [7:0] e);
    xf(0, ADDR_CONV_DATA, 16'h0000);
    chk(s, {8'h00, e}, q);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst <= 0;
    w(1);
    chk("reset", 16'h0000, {st, dn, cf, bz});
    for (int i = 0; i < 4; i++) begin
      lv <= 8'($random(seed));
      xf(1, ADDR_CONV_START, 16'h0001);
      chk("start", 16'h0001, st);
      rc("cleared", 8'h00);
      chk("start clr", 16'h0000, st);
      if (i == 1) begin
        // restart only in the gap between samples
        while (smp) w(1);
        xf(1, ADDR_CONV_START, 16'h0001);
        rc("restart", 8'h00);
      end
      w(40);
      rc("msb", {lv[7], 7'h00});
      repeat (300) if (!dn) @(posedge clk_in);
      w(1);
      chk("done", 16'h0001, dn);
      rc("result", lv);
      xf(1, ADDR_CONV_DATA, {8'hff, ~lv});
      rc("mode0 write", lv);
      xf(1, ADDR_CONV_START, 16'h0000);
      chk("done clr", 16'h0000, dn);
    end
    @(posedge clk_in);
    md <= 1;
    for (int i = 0; i < 6; i++) begin
      d = i == 0 ? lv : i == 1 ? lv + 8'h01 : 8'($random(seed));
      xf(1, ADDR_CONV_DATA, {8'($random(seed)), d});
      chk("cmp clr", 16'h0000, cf);
      w(30);
      chk("cmp", 16'(lv >= d), cf);
      rc("cmp data", d);
    end
    xf(1, 8'h05, 16'h0000);
    rc("unmapped", d);
    xf(1, ADDR_CONV_START, 16'h0001);
    rc("single clr", 8'h00);
    print_verdict();
  end
endmodule
